//--- ddrsc_pkg.sv
// constants, types and helpers shared by the burst-of-two sram core
package ddrsc_pkg;

  // data path shape
  localparam int ADDR_W    = 20;
  localparam int DATA_W    = 18;
  localparam int LANE_W    = 9;
  localparam int LANES     = 2;
  localparam int MEM_IDX_W = 4;
  localparam int MEM_DEPTH = 16;

  // lock wait: stable input clock edges after any loop reset
  localparam int LOCK_CYCLES = 2048;
  localparam int LOCK_CNT_W  = 12;
  localparam logic [LOCK_CNT_W-1:0] LOCK_LAST =
    LOCK_CNT_W'(LOCK_CYCLES - 1);

  // clock-stop detection, a least time so it rounds up
  localparam int CLK_PERIOD_NS = 4;
  localparam int STOP_TIME_NS  = 30;
  localparam int STOP_CYCLES   =
    (STOP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STOP_CNT_W    = 4;
  localparam logic [STOP_CNT_W-1:0] STOP_LAST = STOP_CNT_W'(STOP_CYCLES);

  // half-cycle stages counted from the command edge (stage 0)
  localparam int PIPE_LEN      = 7;
  localparam int WR_BEAT0_STG  = 2;
  localparam int WR_BEAT1_STG  = 3;
  localparam int RD_BEAT0_STG  = 5;
  localparam int RD_BEAT1_STG  = 6;
  localparam int BYP_BEAT0_STG = 2;
  localparam int BYP_BEAT1_STG = 3;

  // write buffer
  localparam int BUF_DEPTH = 2;
  localparam logic [1:0] BUF_FULL = 2'h2;

  typedef enum logic [1:0] {
    DDRSC_LOCKING = 2'b01,
    DDRSC_READY   = 2'b10
  } ddrsc_state_t;

  // two-bit linear burst: second address is the first plus one
  function automatic logic [ADDR_W-1:0] ddrsc_burst_next(
    input logic [ADDR_W-1:0] a
  );
    ddrsc_burst_next = {a[ADDR_W-1:2], a[1:0] + 2'h1};
  endfunction

  function automatic logic [MEM_IDX_W-1:0] ddrsc_idx(
    input logic [ADDR_W-1:0] a
  );
    ddrsc_idx = a[MEM_IDX_W-1:0];
  endfunction

endpackage

//--- ddrsc_core.sv
// device-side command, lock and late-write logic of the ddr sram
// Operation
// - after stable clocks, wait the lock period before accepting commands
// - with the loop bypassed, only logic initialisation happens, no locking
// - clock static over 30 ns resets the loop; relock within lock wait
// - bypass input rising edge resets the loop; relock within lock wait
// - second burst address is first address plus one, two-bit linear
// - strobe low and direction high at k edge starts a read
// - read beats at k_n t+2.5 and k t+3.0
// - strobe low and direction low at k edge starts a two-beat write
// - two active-low lane enables mask each beat; both high aborts it
// - strobe high at k edge is no operation; data outputs go high-z
// - clocks stop only when idle; data bus holds its previous state
// - lock is reached after 2048 stable input clock edges
// - loop bypassed gives one-cycle read latency instead of two and half
module ddrsc_core
  import ddrsc_pkg::*;
(
  // system
  input  wire logic              core_clk,
  input  wire logic              rst,
  // input clocks from the controller
  input  wire logic              k_clk,
  input  wire logic              k_clk_n,
  input  wire logic              loop_enable,
  // command
  input  wire logic              new_addr_strobe_n,
  input  wire logic              rd_wr_sel,
  input  wire logic [ADDR_W-1:0] addr,
  // data bus and lanes
  input  wire logic [DATA_W-1:0] dq_in,
  output      logic [DATA_W-1:0] dq_out,
  output      logic              dq_oe_n,
  input  wire logic              lane0_wr_en_n,
  input  wire logic              lane1_wr_en_n,
  // status
  output      logic              dev_ready,
  output      logic              loop_locked,
  output      logic              wr_overrun
);

  // five control pins plus the two lane enables ride with address and data
  localparam int IN_W = 7 + ADDR_W + DATA_W;

  // every pin passes two flops before logic reads it
  logic [IN_W-1:0]   sync1_q;
  logic [IN_W-1:0]   sync2_q;
  logic              k_prev_q;
  logic              kn_prev_q;
  logic              en_prev_q;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sync1_q   <= '0;
      sync2_q   <= '0;
      k_prev_q  <= 1'b0;
      kn_prev_q <= 1'b0;
      en_prev_q <= 1'b0;
    end else begin
      sync1_q   <= {k_clk, k_clk_n, loop_enable, new_addr_strobe_n,
                    rd_wr_sel, lane0_wr_en_n, lane1_wr_en_n, addr, dq_in};
      sync2_q   <= sync1_q;
      k_prev_q  <= sync2_q[IN_W-1];
      kn_prev_q <= sync2_q[IN_W-2];
      en_prev_q <= sync2_q[IN_W-3];
    end
  end

  logic              k_s;
  logic              kn_s;
  logic              en_s;
  logic              strobe_n_s;
  logic              rd_sel_s;
  logic [LANES-1:0]  lane_n_s;
  logic [ADDR_W-1:0] addr_s;
  logic [DATA_W-1:0] dq_s;

  assign {k_s, kn_s, en_s, strobe_n_s, rd_sel_s, lane_n_s[0], lane_n_s[1],
          addr_s, dq_s} = sync2_q;

  logic k_rise;
  logic kn_rise;
  logic half_tick;
  logic en_rise;

  assign k_rise    = k_s & ~k_prev_q;
  assign kn_rise   = kn_s & ~kn_prev_q;
  assign half_tick = k_rise | kn_rise;
  assign en_rise   = en_s & ~en_prev_q;

  // clock-stop detector: no edge on either clock for the stop time
  logic [STOP_CNT_W-1:0] idle_cnt_q;
  logic                  clk_stopped;

  assign clk_stopped = (idle_cnt_q == STOP_LAST);

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      idle_cnt_q <= '0;
    end else if ((k_s != k_prev_q) || (kn_s != kn_prev_q)) begin
      idle_cnt_q <= '0;
    end else if (!clk_stopped) begin
      idle_cnt_q <= idle_cnt_q + STOP_CNT_W'(1);
    end
  end

  // lock wait; runs in bypass too since internal logic still initialises
  ddrsc_state_t          state_q;
  logic [LOCK_CNT_W-1:0] lock_cnt_q;
  logic                  loop_reset;

  assign loop_reset = clk_stopped | en_rise;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_q    <= DDRSC_LOCKING;
      lock_cnt_q <= '0;
    end else if (loop_reset) begin
      state_q    <= DDRSC_LOCKING;
      lock_cnt_q <= '0;
    end else begin
      case (state_q)
        DDRSC_LOCKING: begin
          if (k_rise) begin
            if (lock_cnt_q == LOCK_LAST) begin
              state_q <= DDRSC_READY;
            end
            lock_cnt_q <= lock_cnt_q + LOCK_CNT_W'(1);
          end
        end
        DDRSC_READY: begin
          state_q <= DDRSC_READY;
        end
        default: begin
          state_q    <= DDRSC_LOCKING;
          lock_cnt_q <= '0;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      dev_ready   <= 1'b0;
      loop_locked <= 1'b0;
    end else begin
      dev_ready   <= (state_q == DDRSC_READY);
      loop_locked <= (state_q == DDRSC_READY) & en_s;
    end
  end

  // half-cycle command pipeline; a stopped clock freezes it
  logic [PIPE_LEN-1:0] rd_pipe_q;
  logic [PIPE_LEN-1:0] wr_pipe_q;
  logic [ADDR_W-1:0]   addr_pipe_q [PIPE_LEN];
  logic                cmd_ok;

  assign cmd_ok = k_rise & ~strobe_n_s & (state_q == DDRSC_READY);

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rd_pipe_q <= '0;
      wr_pipe_q <= '0;
      for (int i = 0; i < PIPE_LEN; i++) begin
        addr_pipe_q[i] <= '0;
      end
    end else if (half_tick) begin
      rd_pipe_q <= {rd_pipe_q[PIPE_LEN-2:0], cmd_ok & rd_sel_s};
      wr_pipe_q <= {wr_pipe_q[PIPE_LEN-2:0], cmd_ok & ~rd_sel_s};
      addr_pipe_q[0] <= addr_s;
      for (int i = 1; i < PIPE_LEN; i++) begin
        addr_pipe_q[i] <= addr_pipe_q[i-1];
      end
    end
  end

  // read beats; bypass takes the short latency
  logic [DATA_W-1:0] mem_q [MEM_DEPTH];
  logic              rd_beat0;
  logic              rd_beat1;
  logic              rd_access;

  always_comb begin
    if (en_s) begin
      rd_beat0 = rd_pipe_q[RD_BEAT0_STG-1];
      rd_beat1 = rd_pipe_q[RD_BEAT1_STG-1];
    end else begin
      rd_beat0 = rd_pipe_q[BYP_BEAT0_STG-1];
      rd_beat1 = rd_pipe_q[BYP_BEAT1_STG-1];
    end
  end

  assign rd_access = half_tick & (rd_beat0 | rd_beat1);

  // outputs only move on a clock edge, so a stopped clock holds the bus
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      dq_out  <= '0;
      dq_oe_n <= 1'b1;
    end else if (half_tick) begin
      if (rd_beat0 && en_s) begin
        dq_out  <= mem_q[ddrsc_idx(addr_pipe_q[RD_BEAT0_STG-1])];
        dq_oe_n <= 1'b0;
      end else if (rd_beat0) begin
        dq_out  <= mem_q[ddrsc_idx(addr_pipe_q[BYP_BEAT0_STG-1])];
        dq_oe_n <= 1'b0;
      end else if (rd_beat1 && en_s) begin
        dq_out  <= mem_q[ddrsc_idx(
                     ddrsc_burst_next(addr_pipe_q[RD_BEAT1_STG-1]))];
        dq_oe_n <= 1'b0;
      end else if (rd_beat1) begin
        dq_out  <= mem_q[ddrsc_idx(
                     ddrsc_burst_next(addr_pipe_q[BYP_BEAT1_STG-1]))];
        dq_oe_n <= 1'b0;
      end else begin
        dq_oe_n <= 1'b1;
      end
    end
  end

  // write beat capture; aborted beats never enter the buffer
  logic              wb_valid;
  logic              wb_ready;
  logic [ADDR_W-1:0] wb_addr;

  always_comb begin
    wb_valid = 1'b0;
    wb_addr  = addr_pipe_q[WR_BEAT0_STG-1];
    if (half_tick && wr_pipe_q[WR_BEAT0_STG-1]) begin
      wb_valid = ~(&lane_n_s);
    end else if (half_tick && wr_pipe_q[WR_BEAT1_STG-1]) begin
      wb_valid = ~(&lane_n_s);
      wb_addr  = ddrsc_burst_next(addr_pipe_q[WR_BEAT1_STG-1]);
    end
  end

  // two-entry buffer; array write yields to a read access
  logic [DATA_W-1:0] buf_data_q [BUF_DEPTH];
  logic [LANES-1:0]  buf_lane_q [BUF_DEPTH];
  logic [ADDR_W-1:0] buf_addr_q [BUF_DEPTH];
  logic              buf_wp_q;
  logic              buf_rp_q;
  logic [1:0]        buf_cnt_q;
  logic              buf_push;
  logic              buf_pop;

  assign wb_ready = (buf_cnt_q != BUF_FULL);
  assign buf_push = wb_valid & wb_ready;
  assign buf_pop  = (buf_cnt_q != 2'h0) & ~rd_access;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      buf_wp_q  <= 1'b0;
      buf_rp_q  <= 1'b0;
      buf_cnt_q <= 2'h0;
      for (int i = 0; i < BUF_DEPTH; i++) begin
        buf_data_q[i] <= '0;
        buf_lane_q[i] <= '0;
        buf_addr_q[i] <= '0;
      end
    end else begin
      if (buf_push) begin
        buf_data_q[buf_wp_q] <= dq_s;
        buf_lane_q[buf_wp_q] <= ~lane_n_s;
        buf_addr_q[buf_wp_q] <= wb_addr;
        buf_wp_q             <= ~buf_wp_q;
      end
      if (buf_pop) begin
        buf_rp_q <= ~buf_rp_q;
      end
      buf_cnt_q <= buf_cnt_q + {1'b0, buf_push} - {1'b0, buf_pop};
    end
  end

  // a beat lost to a full buffer is flagged until reset
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wr_overrun <= 1'b0;
    end else if (wb_valid && !wb_ready) begin
      wr_overrun <= 1'b1;
    end
  end

  // array: lane 0 gates bits 0-8, lane 1 gates bits 9-17
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < MEM_DEPTH; i++) begin
        mem_q[i] <= '0;
      end
    end else if (buf_pop) begin
      for (int l = 0; l < LANES; l++) begin
        if (buf_lane_q[buf_rp_q][l]) begin
          mem_q[ddrsc_idx(buf_addr_q[buf_rp_q])][l*LANE_W +: LANE_W] <=
            buf_data_q[buf_rp_q][l*LANE_W +: LANE_W];
        end
      end
    end
  end

endmodule

//--- ddrsc_checker_assertions.sv
// concurrent checks on the ddr sram core ports
module ddrsc_checker
  import ddrsc_pkg::*;
(
  // system and clocks
  input wire logic              core_clk,
  input wire logic              rst,
  input wire logic              k_clk,
  input wire logic              k_clk_n,
  input wire logic              loop_enable,
  // command
  input wire logic              new_addr_strobe_n,
  input wire logic              rd_wr_sel,
  // outputs
  input wire logic [DATA_W-1:0] dq_out,
  input wire logic              dq_oe_n,
  input wire logic              dev_ready,
  input wire logic              loop_locked
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  logic        k_q;
  logic        kn_q;
  logic        krise;
  logic [3:0]  stop_q;
  logic [5:0]  age_q;
  logic [11:0] kcnt_q;
  assign krise = k_clk && !k_q;
  // counters saturate so long idle stretches cannot wrap
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      k_q <= 1'b0;
      kn_q <= 1'b0;
      stop_q <= 4'h0;
      age_q <= 6'h0;
      kcnt_q <= 12'h000;
    end else begin
      k_q <= k_clk;
      kn_q <= k_clk_n;
      stop_q <= (k_clk != k_q || k_clk_n != kn_q) ? 4'h0 :
                stop_q + {3'h0, stop_q != 4'hf};
      age_q <= (krise && !new_addr_strobe_n && rd_wr_sel) ? 6'h00 :
               age_q + {5'h00, age_q != 6'h3f};
      kcnt_q <= dev_ready ? 12'h000 :
                kcnt_q + {11'h000, krise && kcnt_q != 12'hfff};
    end
  end
  sequence s_rd_cmd;
    krise && !new_addr_strobe_n && rd_wr_sel && dev_ready;
  endsequence
  sequence s_beat_pair;
    !dq_oe_n [*4];
  endsequence
  AST_LOCK_MIN: assert property (
    $rose(dev_ready) |-> kcnt_q >= LOCK_CYCLES - 8)
    else $error("ready before the lock wait ended");
  AST_BYP_UNLOCKED: assert property (
    !loop_enable [*8] |-> !loop_locked)
    else $error("locked while the loop is bypassed");
  AST_STOP_RESET: assert property (
    stop_q == 4'he |-> !dev_ready)
    else $error("stopped clock did not reset the loop");
  AST_BYP_RESET: assert property (
    $rose(loop_enable) |-> ##[1:8] !dev_ready)
    else $error("bypass rise did not reset the loop");
  AST_READ_LAT: assert property (
    s_rd_cmd ##0 loop_enable |-> ##[12:16] !dq_oe_n)
    else $error("read beat late or missing");
  AST_BYP_LAT: assert property (
    s_rd_cmd ##0 !loop_enable |-> ##[6:10] !dq_oe_n)
    else $error("bypass read beat late or missing");
  AST_BEAT_LEN: assert property (
    $fell(dq_oe_n) |-> s_beat_pair)
    else $error("read burst shorter than two beats");
  AST_NOP_HIGHZ: assert property (
    age_q > 6'h18 |-> dq_oe_n)
    else $error("bus driven with no read pending");
  AST_STOP_HOLD: assert property (
    stop_q > 4'h5 |-> $stable(dq_oe_n) && $stable(dq_out))
    else $error("bus changed while clocks stopped");
endmodule

bind ddrsc_core ddrsc_checker ddrsc_checker_i (.core_clk, .rst, .k_clk,
  .k_clk_n, .loop_enable, .new_addr_strobe_n, .rd_wr_sel, .dq_out, .dq_oe_n,
  .dev_ready, .loop_locked);

//--- ddrsc_kclk_model.sv
// controller-side model making the k and k_n input clocks
module ddrsc_kclk_model (
  // system
  input  wire logic core_clk,
  input  wire logic run,
  // clocks to the sram
  output      logic k_clk,
  output      logic k_clk_n
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [1:0] ph_q;
  initial ph_q = 2'h0;
  // a stopped clock holds its level, never floats
  always @(posedge core_clk) begin
    if (run) begin
      ph_q <= ph_q + 2'h1;
    end
  end
  // 16 ns period, k_n the exact inverse
  assign k_clk = ph_q[1];
  assign k_clk_n = ~ph_q[1];
endmodule

//--- testbench.sv
// self-checking bench for the ddr sram core
module testbench
  import ddrsc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic core_clk, rst, run, loop_enable, strobe_n, rd_sel;
  logic k_clk, k_clk_n, dq_oe_n, dev_ready, loop_locked, wr_overrun;
  logic [1:0] lanes;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] dq_in, dq_out, dq_drv;
  logic [DATA_W-1:0] mem [MEM_DEPTH];
  int miscompares = 0;
  int n_compared = 0;
  int cyc = 0;
  // one wire: the sram wins while it drives
  assign dq_in = dq_oe_n ? dq_drv : dq_out;
  ddrsc_kclk_model ddrsc_kclk_model_i (.core_clk(core_clk), .run(run),
    .k_clk(k_clk), .k_clk_n(k_clk_n));
  ddrsc_core ddrsc_core_i (.core_clk(core_clk), .rst(rst), .k_clk(k_clk),
    .k_clk_n(k_clk_n), .loop_enable(loop_enable),
    .new_addr_strobe_n(strobe_n), .rd_wr_sel(rd_sel), .addr(addr),
    .dq_in(dq_in), .dq_out(dq_out), .dq_oe_n(dq_oe_n),
    .lane0_wr_en_n(lanes[0]), .lane1_wr_en_n(lanes[1]),
    .dev_ready(dev_ready), .loop_locked(loop_locked),
    .wr_overrun(wr_overrun));
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 50000) begin
      miscompares++;
      wrap_up();
    end
  end
  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic cmp(input logic [DATA_W-1:0] got, exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: data %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp_b(input logic got, exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: flag %b expected %b", $time, got, exp);
    end
  endtask
  task automatic cmd(input logic s, r, input logic [ADDR_W-1:0] a);
    @(posedge k_clk);
    #1;
    strobe_n = s;
    rd_sel = r;
    addr = a;
  endtask
  // expected array image after one masked beat
  task automatic upd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                     input logic [1:0] l);
    logic [DATA_W-1:0] m;
    m = {{LANE_W{~l[1]}}, {LANE_W{~l[0]}}};
    mem[a[3:0]] = (mem[a[3:0]] & ~m) | (d & m);
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d0,
                    d1, input logic [1:0] l0, l1);
    cmd(1'b0, 1'b0, a);
    cmd(1'b1, 1'b1, a);
    dq_drv = d0;
    lanes = l0;
    @(posedge k_clk_n);
    #1;
    dq_drv = d1;
    lanes = l1;
    upd(a, d0, l0);
    upd({a[ADDR_W-1:2], a[1:0] + 2'h1}, d1, l1);
    @(posedge k_clk);
    #1;
    dq_drv = ~d1;
    lanes = 2'h3;
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, input int lo, hi);
    int n;
    logic [3:0] a1;
    n = 0;
    a1 = {a[3:2], a[1:0] + 2'h1};
    cmd(1'b0, 1'b1, a);
    while (dq_oe_n !== 1'b0 && n < 30) begin
      @(posedge core_clk);
      #1;
      n++;
      if (n == 4) strobe_n = 1'b1;
    end
    cmp_b(n >= lo && n <= hi, 1'b1);
    cmp(dq_out, mem[a[3:0]]);
    repeat (2) @(posedge core_clk);
    #1;
    cmp(dq_out, mem[a1]);
    repeat (8) @(posedge core_clk);
    #1;
    cmp_b(dq_oe_n, 1'b1);
  endtask
  task automatic wait_ready(input int n0);
    int n;
    logic drv;
    n = n0;
    drv = 1'b0;
    while (dev_ready !== 1'b1 && n < 3000) begin
      @(posedge k_clk);
      #1;
      n++;
      drv = drv | (dq_oe_n !== 1'b1);
    end
    cmp_b(n >= LOCK_CYCLES - 2 && n <= LOCK_CYCLES + 4, 1'b1);
    cmp_b(drv, 1'b0);
  endtask
  task automatic t_power_up();
    cmd(1'b0, 1'b1, 20'h0_0003);
    cmd(1'b1, 1'b1, 20'h0_0003);
    wait_ready(2);
    cmp_b(loop_locked, 1'b1);
  endtask
  task automatic t_write_read();
    wr(20'h0_0003, 18'h2_5a5a, 18'h3_c3c3, 2'h0, 2'h2);
    wr(20'h0_0008, 18'h1_2345, 18'h2_abcd, 2'h3, 2'h1);
    repeat (4) @(posedge k_clk);
    #1;
    rd(20'h0_0003, 12, 17);
    rd(20'h0_0008, 12, 17);
    cmp_b(wr_overrun, 1'b0);
  endtask
  task automatic t_bypass();
    loop_enable = 1'b0;
    repeat (8) @(posedge core_clk);
    #1;
    cmp_b(loop_locked, 1'b0);
    rd(20'h0_0008, 5, 10);
    loop_enable = 1'b1;
    repeat (6) @(posedge core_clk);
    #1;
    cmp_b(dev_ready, 1'b0);
    wait_ready(1);
    cmp_b(loop_locked, 1'b1);
  endtask
  task automatic t_clock_stop();
    logic [DATA_W-1:0] last;
    last = dq_out;
    run = 1'b0;
    repeat (16) @(posedge core_clk);
    #1;
    cmp_b(dev_ready, 1'b0);
    cmp_b(dq_oe_n, 1'b1);
    cmp(dq_out, last);
    run = 1'b1;
    wait_ready(0);
    rd(20'h0_0003, 12, 17);
  endtask
  initial begin
    rst = 1'b1;
    run = 1'b1;
    loop_enable = 1'b1;
    strobe_n = 1'b1;
    rd_sel = 1'b1;
    addr = '0;
    dq_drv = '0;
    lanes = 2'h3;
    foreach (mem[i]) mem[i] = '0;
    repeat (6) @(posedge core_clk);
    #1;
    rst = 1'b0;
    t_power_up();
    t_write_read();
    t_bypass();
    t_clock_stop();
    wrap_up();
  end
endmodule
